// file: rtl/mafw_consts.svh
// Offsets, field positions, reset values and table constants of the monitor flag block
`ifndef MAFW_CONSTS_SVH
`define MAFW_CONSTS_SVH

// Register offsets on the internal register port
`define MAFW_OFS_CRIT_LO 8'h70
`define MAFW_OFS_CRIT_HI 8'h71
`define MAFW_OFS_MINOR_LO 8'h74
`define MAFW_OFS_MINOR_HI 8'h75
`define MAFW_OFS_PIN_CTRL 8'h6e
`define MAFW_OFS_INDEX 8'h7f
`define MAFW_OFS_LATCH_CFG 8'h8c

// Reset values
`define MAFW_RST_FLAGS 8'h00
`define MAFW_RST_LATCH_CFG 8'h00
`define MAFW_RST_PIN_CTRL 4'hf
`define MAFW_RST_INDEX 7'h00

// Latch mode field of the latch configuration register
`define MAFW_LATCH_MSB 7
`define MAFW_LATCH_LSB 4

// Flag bit positions in the low flag registers
`define MAFW_BIT_TEMP_HI 7
`define MAFW_BIT_TEMP_LO 6
`define MAFW_BIT_VOLT_HI 5
`define MAFW_BIT_VOLT_LO 4
`define MAFW_BIT_BIAS_HI 3
`define MAFW_BIT_BIAS_LO 2
`define MAFW_BIT_TXP_HI 1
`define MAFW_BIT_TXP_LO 0
// Flag bit positions in the high flag registers
`define MAFW_BIT_RXP_HI 7
`define MAFW_BIT_RXP_LO 6

// Pin control/status field positions
`define MAFW_PIN_TXRATE 0
`define MAFW_PIN_RXRATE 1
`define MAFW_PIN_GPO 2
`define MAFW_PIN_GPO2 3
`define MAFW_PIN_LOS 4
`define MAFW_PIN_FAULT 5
`define MAFW_PIN_TXOFF 6

// Compensation table index arithmetic
`define MAFW_INDEX_OFFSET 18'sd23
`define MAFW_INDEX_MAX 18'sd75
`define MAFW_HYST_UP 18'sd43
`define MAFW_HYST_DOWN 18'sd48
`define MAFW_FIRST_CONT 7'd64

// Table bases: first upper page, then continuation page
`define MAFW_BASE_APC 8'h00
`define MAFW_BASE_MOD 8'h40
`define MAFW_BASE_FLT 8'h80
`define MAFW_BASE_BIAS 8'hc0
`define MAFW_CONT_APC 8'h58
`define MAFW_CONT_MOD 8'h64
`define MAFW_CONT_FLT 8'h70
`define MAFW_CONT_BIAS 8'h7c

`endif

// file: rtl/mafw_pkg.sv
// Types shared by the monitor flag block
package mafw_pkg;

    // One set of monitor quantities, also used for limit sets
    typedef struct packed {
        logic signed [15:0] temp;   // Whole degrees C, two's complement
        logic [15:0] supply;
        logic [15:0] bias;
        logic [15:0] txPower;
        logic [15:0] rxPower;
    } mafw_meas_s;

    // Upper and lower limit of every quantity
    typedef struct packed {
        mafw_meas_s high;
        mafw_meas_s low;
    } mafw_limits_s;

    // Register port request from the serial engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } mafw_reg_req_s;

    // Register port answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mafw_reg_rsp_s;

    // Table entry address: page select and byte address
    typedef struct packed {
        logic contPage;             // High: continuation page
        logic [7:0] addr;
    } mafw_tab_addr_s;

    // Pin levels, one bit per control/status pin
    typedef struct packed {
        logic txOff;
        logic fault;
        logic los;
        logic gpo2;
        logic general_output;
        logic rxRate;
        logic txRate;
    } mafw_pins_s;

    // Open-drain pin group drive, bit order as in mafw_pins_s
    typedef logic [5:0] mafw_od_t;

endpackage

// file: rtl/mafw_pin_sync.sv
// Two-stage synchroniser for the control and status pin levels
`timescale 1ns/1ps
module mafw_pin_sync
    import mafw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire mafw_pins_s pinAsync,
    output mafw_pins_s pinSync
);

    // Both stages in one state word
    typedef struct packed {
        mafw_pins_s stage1;         // Metastable stage, read only by stage2
        mafw_pins_s stage2;
    } mafw_sync_s;

    mafw_sync_s state;
    mafw_sync_s next_state;

    // Shift pins through the two stages
    always_comb begin
        next_state.stage1 = pinAsync;
        next_state.stage2 = state.stage1;
    end

    // Clear to zero; first two edges after release may show stale zeros
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pinSync = state.stage2;

endmodule

// file: rtl/mafw_flags.sv
// Alarm/warning flags, compensation table index and open-drain status pins
`timescale 1ns/1ps
`include "mafw_consts.svh"
module mafw_flags
    import mafw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic tempValid,
    input wire logic evalStrobe,
    input wire mafw_meas_s meas,
    input wire mafw_limits_s critLimits,
    input wire mafw_limits_s minorLimits,
    input wire logic lossDetect,
    input wire logic faultDetect,
    input wire mafw_reg_req_s regReq,
    output mafw_reg_rsp_s regRsp,
    output logic [6:0] tableIndex,
    output mafw_tab_addr_s [3:0] tableAddr,
    input wire mafw_pins_s pinIn,
    output mafw_od_t pinOut,
    output mafw_od_t pinOeN
);

    // Whole state of the block
    typedef struct packed {
        logic [7:0] critLo;         // Critical flags, first register
        logic [7:0] critHi;         // Critical flags, second register
        logic [7:0] minorLo;        // Minor flags, first register
        logic [7:0] minorHi;        // Minor flags, second register
        logic [7:0] latchCfg;       // Latch mode in the top nibble
        logic [3:0] pinCtrl;        // Host drive for rate and general pins
        logic [6:0] index;          // Compensation table index
        logic indexLoaded;          // First temperature seen
        logic txOffPrev;            // Synced transmit off, one cycle late
        logic [7:0] rdData;
        logic rdValid;
        mafw_tab_addr_s [3:0] addr;
    } mafw_state_s;

    mafw_state_s state;
    mafw_state_s next_state;
    mafw_pins_s pinSync;            // Pin levels after two flops

    // Pin levels cross into the clock domain here
    mafw_pin_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pinAsync(pinIn),
        .pinSync(pinSync)
    );

    // Raw index: floor(t/2) plus offset, clamped to the table span
    // Arithmetic shift rounds negative halves down, as the floor needs
    function automatic logic [6:0] rawIndex(input logic signed [15:0] t);
        logic signed [17:0] v;
        v = 18'(t >>> 1) + `MAFW_INDEX_OFFSET;
        if (v < 18'sd0) begin
            return 7'd0;
        end else if (v > `MAFW_INDEX_MAX) begin
            return 7'(`MAFW_INDEX_MAX);
        end else begin
            return v[6:0];
        end
    endfunction

    // Index with hysteresis: move only past midpoint of next entry
    // Whole-degree thresholds sit just past each neighbour's midpoint
    // Trades 1 degree of lag for an index that never dithers
    function automatic logic [6:0] hystIndex(input logic signed [15:0] t,
                                             input logic [6:0] cur);
        logic [6:0] raw;
        logic signed [17:0] t18;
        logic signed [17:0] twice;
        raw = rawIndex(t);
        t18 = 18'(t);
        twice = $signed({10'h000, cur, 1'b0});
        if (raw > cur && t18 >= twice - `MAFW_HYST_UP) begin
            return raw;
        end else if (raw < cur && t18 <= twice - `MAFW_HYST_DOWN) begin
            return raw;
        end else begin
            return cur;
        end
    endfunction

    // Entry address in the first page or the continuation page
    // Entries from 64 on restart at the continuation page's own base
    function automatic mafw_tab_addr_s tabAddr(input logic [6:0] idx,
                                               input logic [7:0] base,
                                               input logic [7:0] cont);
        mafw_tab_addr_s a;
        if (idx < `MAFW_FIRST_CONT) begin
            a.contPage = 1'b0;
            a.addr = base + {1'b0, idx};
        end else begin
            a.contPage = 1'b1;
            a.addr = cont + {1'b0, idx - `MAFW_FIRST_CONT};
        end
        return a;
    endfunction

    // Strict high/low comparison pair of one quantity set
    function automatic logic [9:0] compareSet(input mafw_meas_s m,
                                              input mafw_limits_s l);
        logic [9:0] c;
        c = '0;
        c[9] = m.rxPower > l.high.rxPower;
        c[8] = m.rxPower < l.low.rxPower;
        c[`MAFW_BIT_TEMP_HI] = m.temp > l.high.temp;
        c[`MAFW_BIT_TEMP_LO] = m.temp < l.low.temp;
        c[`MAFW_BIT_VOLT_HI] = m.supply > l.high.supply;
        c[`MAFW_BIT_VOLT_LO] = m.supply < l.low.supply;
        c[`MAFW_BIT_BIAS_HI] = m.bias > l.high.bias;
        c[`MAFW_BIT_BIAS_LO] = m.bias < l.low.bias;
        c[`MAFW_BIT_TXP_HI] = m.txPower > l.high.txPower;
        c[`MAFW_BIT_TXP_LO] = m.txPower < l.low.txPower;
        return c;
    endfunction

    // Next flag byte from old value, clear and fresh conditions
    // Clear is applied before the set, so an event in the clear cycle wins
    function automatic logic [7:0] flagNext(input logic [7:0] old,
                                            input logic [7:0] cond,
                                            input logic clr,
                                            input logic eval,
                                            input logic latched);
        logic [7:0] kept;
        kept = clr ? 8'h00 : old;
        if (!eval) begin
            return kept;
        end else if (latched) begin
            return kept | cond;
        end else begin
            return cond;                         // Follow mode tracks condition
        end
    endfunction

    logic [9:0] critCond;           // Critical conditions this cycle
    logic [9:0] minorCond;          // Minor conditions this cycle
    logic latched;                  // Latch mode field is zero
    logic txOffFall;                // Transmit off released
    logic rdHit;                    // Read strobe on any address

    // Conditions and decoded strobes
    // Temperature compares signed, the other quantities unsigned
    // Synced level one cycle late against now gives the release edge
    always_comb begin
        critCond = compareSet(meas, critLimits);
        minorCond = compareSet(meas, minorLimits);
        latched = state.latchCfg[`MAFW_LATCH_MSB:`MAFW_LATCH_LSB] == 4'h0;
        txOffFall = state.txOffPrev && !pinSync.txOff;
        rdHit = regReq.rd;
    end

    // Register update, flag handling and index tracking
    // Defaults keep every field but the read answer and txOffPrev, so unlisted writes change nothing
    always_comb begin
        next_state = state;
        next_state.txOffPrev = pinSync.txOff;
        next_state.rdValid = rdHit;
        next_state.rdData = 8'h00;

        // Read data captured before any read clear
        // Read data stays zero in cycles without a read
        if (rdHit) begin
            case (regReq.addr)
                `MAFW_OFS_CRIT_LO: begin
                    next_state.rdData = state.critLo;
                end
                `MAFW_OFS_CRIT_HI: begin
                    next_state.rdData = state.critHi;
                end
                `MAFW_OFS_MINOR_LO: begin
                    next_state.rdData = state.minorLo;
                end
                `MAFW_OFS_MINOR_HI: begin
                    next_state.rdData = state.minorHi;
                end
                `MAFW_OFS_LATCH_CFG: begin
                    next_state.rdData = state.latchCfg;
                end
                `MAFW_OFS_INDEX: begin
                    next_state.rdData = {1'b0, state.index};
                end
                `MAFW_OFS_PIN_CTRL: begin
                    // Pin levels, not the written drive values
                    next_state.rdData = {1'b0, pinSync};
                end
                default: begin
                    next_state.rdData = 8'h00;            // Unmapped reads zero
                end
            endcase
        end

        // Host writes; flag registers are read-only
        // Writes to flag, index and unmapped offsets are refused
        if (regReq.wr) begin
            case (regReq.addr)
                `MAFW_OFS_LATCH_CFG: begin
                    next_state.latchCfg = regReq.data;
                end
                `MAFW_OFS_PIN_CTRL: begin
                    next_state.pinCtrl = regReq.data[3:0];
                end
                default: begin
                    next_state.pinCtrl = state.pinCtrl;   // Ignored
                end
            endcase
        end

        // Flags: transmit off only clears on release, never gates events
        // Each register clears on a read of its own offset or on transmit-off release
        next_state.critLo = flagNext(state.critLo, critCond[7:0],
            txOffFall || (rdHit && regReq.addr == `MAFW_OFS_CRIT_LO),
            evalStrobe, latched);
        next_state.critHi = flagNext(state.critHi, {critCond[9:8], 6'h00},
            txOffFall || (rdHit && regReq.addr == `MAFW_OFS_CRIT_HI),
            evalStrobe, latched);
        next_state.minorLo = flagNext(state.minorLo, minorCond[7:0],
            txOffFall || (rdHit && regReq.addr == `MAFW_OFS_MINOR_LO),
            evalStrobe, latched);
        next_state.minorHi = flagNext(state.minorHi, {minorCond[9:8], 6'h00},
            txOffFall || (rdHit && regReq.addr == `MAFW_OFS_MINOR_HI),
            evalStrobe, latched);

        // First temperature loads directly, later ones use hysteresis
        // Skipping hysteresis at start avoids holding entry 0 when the first reading is -44
        if (tempValid) begin
            next_state.indexLoaded = 1'b1;
            if (state.indexLoaded) begin
                next_state.index = hystIndex(meas.temp, state.index);
            end else begin
                next_state.index = rawIndex(meas.temp);
            end
        end

        // Table addresses follow the index one cycle later
        next_state.addr[0] = tabAddr(state.index, `MAFW_BASE_APC, `MAFW_CONT_APC);
        next_state.addr[1] = tabAddr(state.index, `MAFW_BASE_MOD, `MAFW_CONT_MOD);
        next_state.addr[2] = tabAddr(state.index, `MAFW_BASE_FLT, `MAFW_CONT_FLT);
        next_state.addr[3] = tabAddr(state.index, `MAFW_BASE_BIAS, `MAFW_CONT_BIAS);
    end

    // State register; reset equals a power cycle for the flags
    // Edge detector and sync both restart low, so reset makes no false release
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state.critLo <= `MAFW_RST_FLAGS;
            state.critHi <= `MAFW_RST_FLAGS;
            state.minorLo <= `MAFW_RST_FLAGS;
            state.minorHi <= `MAFW_RST_FLAGS;
            state.latchCfg <= `MAFW_RST_LATCH_CFG;
            state.pinCtrl <= `MAFW_RST_PIN_CTRL;
            state.index <= `MAFW_RST_INDEX;
            state.indexLoaded <= 1'b0;
            state.txOffPrev <= 1'b0;
            state.rdData <= 8'h00;
            state.rdValid <= 1'b0;
            state.addr <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Answer and index outputs straight from flops
    // Host reads see the answer one cycle after the request, never sooner
    assign regRsp.valid = state.rdValid;
    assign regRsp.data = state.rdData;
    assign tableIndex = state.index;
    assign tableAddr = state.addr;

    // Detector pins skip the flops; their drive follows the inputs at once
    // Open-drain: output always low, enable active while pulling low.
    // A released pin floats high unless something outside pulls it down.
    assign pinOut = 6'h00;
    assign pinOeN[`MAFW_PIN_TXRATE] = state.pinCtrl[0];
    assign pinOeN[`MAFW_PIN_RXRATE] = state.pinCtrl[1];
    assign pinOeN[`MAFW_PIN_GPO] = state.pinCtrl[2];
    assign pinOeN[`MAFW_PIN_GPO2] = state.pinCtrl[3];
    assign pinOeN[`MAFW_PIN_LOS] = lossDetect;
    assign pinOeN[`MAFW_PIN_FAULT] = faultDetect;

endmodule

// file: test/mafw_flags_chk.sv
// Port-level assertions for the monitor flag block
`timescale 1ns/1ps
`include "mafw_consts.svh"
module mafw_flags_chk
    import mafw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic tempValid,
    input wire logic evalStrobe,
    input wire mafw_meas_s meas,
    input wire mafw_limits_s critLimits,
    input wire mafw_limits_s minorLimits,
    input wire logic lossDetect,
    input wire logic faultDetect,
    input wire mafw_reg_req_s regReq,
    input wire mafw_reg_rsp_s regRsp,
    input wire logic [6:0] tableIndex,
    input wire mafw_tab_addr_s [3:0] tableAddr,
    input wire mafw_pins_s pinIn,
    input wire mafw_od_t pinOut,
    input wire mafw_od_t pinOeN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Entry address of index k; continuation page from entry 64 on
    function automatic mafw_tab_addr_s ea(input logic [6:0] k, input logic [7:0] b,
                                          input logic [7:0] c);
        return (k >= `MAFW_FIRST_CONT) ? {1'b1, 8'(c + k - 8'h40)} : {1'b0, 8'(b + k)};
    endfunction

    // Read request at one offset
    sequence s_rd(logic [7:0] a);
        regReq.rd && regReq.addr == a;
    endsequence

    // Strobe with temperature above the critical upper limit
    sequence s_hot;
        evalStrobe && meas.temp > critLimits.high.temp;
    endsequence

    a_answer_one: assert property (##1 regRsp.valid == $past(regReq.rd))
        else $error("read answer not one cycle after request");
    a_index_read: assert property (s_rd(`MAFW_OFS_INDEX) |=> regRsp.data == {1'b0, $past(tableIndex)})
        else $error("index register differs from index");
    a_index_span: assert property (tableIndex <= 7'd75)
        else $error("index beyond last entry");
    a_index_hold: assert property (!tempValid |=> $stable(tableIndex))
        else $error("index moved without fresh temperature");
    a_table_addr: assert property (tempValid ##1 1'b1 |=>
        tableAddr[0] == ea($past(tableIndex), `MAFW_BASE_APC, `MAFW_CONT_APC) &&
        tableAddr[1] == ea($past(tableIndex), `MAFW_BASE_MOD, `MAFW_CONT_MOD) &&
        tableAddr[2] == ea($past(tableIndex), `MAFW_BASE_FLT, `MAFW_CONT_FLT) &&
        tableAddr[3] == ea($past(tableIndex), `MAFW_BASE_BIAS, `MAFW_CONT_BIAS))
        else $error("table address not index plus base");
    a_pins_od: assert property (pinOut == '0 && pinOeN[4] == lossDetect && pinOeN[5] == faultDetect)
        else $error("status pin not open drain");
    a_hot_flag: assert property (s_hot ##2 s_rd(`MAFW_OFS_CRIT_LO) |=> regRsp.data[7])
        else $error("temperature alarm bit not set");
    a_read_clear: assert property (regReq.rd && regReq.addr == `MAFW_OFS_CRIT_LO && !evalStrobe
        ##1 !evalStrobe ##1 s_rd(`MAFW_OFS_CRIT_LO) |=> regRsp.data == 8'h00)
        else $error("flags survive a read");
    a_spare_zero: assert property (regReq.rd && (regReq.addr == 8'h71 || regReq.addr == 8'h75)
        |=> regRsp.data[5:0] == 6'h00)
        else $error("unused high flag bits set");
endmodule

// file: test/mafw_pin_env.sv
// Far-side pin model: pull-ups, external open-drain drivers, transmit-off
`timescale 1ns/1ps
module mafw_pin_env
    import mafw_pkg::*;
(
    input wire mafw_od_t pinOut,
    input wire mafw_od_t pinOeN,
    input wire mafw_od_t extLowN,   // External drivers, low pulls the wire
    input wire logic txOffLevel,    // Host transmit-off level
    output mafw_pins_s pinIn
);
    // Wired-AND with pull-ups; any party may hold a pin low
    assign pinIn = {txOffLevel, (pinOeN | pinOut) & extLowN};
endmodule

// file: test/tb.sv
// Self-checking bench of the monitor flag block
`timescale 1ns/1ps
module tb
    import mafw_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tempValid = 1'b0;
    logic evalStrobe = 1'b0;
    logic lossDetect = 1'b1;
    logic faultDetect = 1'b1;
    logic txOffLevel = 1'b0;   // Transmit-off pin level
    mafw_od_t extLowN = '1;    // External drivers all released
    mafw_meas_s meas = '0;
    mafw_limits_s critLimits = '0;
    mafw_limits_s minorLimits = '0;
    mafw_reg_req_s regReq = '0;
    mafw_reg_rsp_s regRsp;
    logic [6:0] tableIndex;
    mafw_tab_addr_s [3:0] tableAddr;
    mafw_pins_s pinIn;
    mafw_od_t pinOut;
    mafw_od_t pinOeN;
    int errTotal = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] ofs [4] = '{8'h70, 8'h71, 8'h74, 8'h75};
    // Reset-value offsets and values; corner temperatures of the index walk
    logic [7:0] ra [8] = '{8'h70, 8'h71, 8'h74, 8'h75, 8'h8c, 8'h10, 8'h7f, 8'h6e};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f};
    int tl [8] = '{-45, 100, 101, 102, 98, 97, -200, 300};
    bit followMode = 1'b0;     // Latch field nonzero in the design
    // Limits that no nonnegative value can cross
    localparam mafw_limits_s quietLim = {16'sh7fff, {4{16'hffff}}, 80'h0};

    mafw_flags i_mafw_flags (.ref_clk(ref_clk), .sys_rst(sys_rst), .tempValid(tempValid),
        .evalStrobe(evalStrobe), .meas(meas), .critLimits(critLimits),
        .minorLimits(minorLimits), .lossDetect(lossDetect), .faultDetect(faultDetect),
        .regReq(regReq), .regRsp(regRsp), .tableIndex(tableIndex), .tableAddr(tableAddr),
        .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN));
    mafw_pin_env i_mafw_pin_env (.pinOut(pinOut), .pinOeN(pinOeN), .extLowN(extLowN),
        .txOffLevel(txOffLevel), .pinIn(pinIn));

    // 10 MHz reference clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errTotal++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (errTotal == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Read one register; answer must come one edge later
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regReq.rd <= 1'b1;
        regReq.addr <= a;
        @(posedge ref_clk);
        regReq.rd <= 1'b0;
        #1;
        chk(16'(regRsp.valid), 16'h0001);
        d = regRsp.data;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regReq.wr <= 1'b1;
        regReq.addr <= a;
        regReq.data <= v;
        @(posedge ref_clk);
        regReq.wr <= 1'b0;
    endtask

    function automatic logic [15:0] rnd();
        return 16'($urandom_range(0, 15));
    endfunction

    // Expected low flag byte: high/low of temp, supply, bias, tx power
    function automatic logic [7:0] expLo(input mafw_meas_s m, input mafw_limits_s l);
        return {m.temp > l.high.temp, m.temp < l.low.temp, m.supply > l.high.supply,
            m.supply < l.low.supply, m.bias > l.high.bias, m.bias < l.low.bias,
            m.txPower > l.high.txPower, m.txPower < l.low.txPower};
    endfunction

    function automatic logic [7:0] expHi(input mafw_meas_s m, input mafw_limits_s l);
        return {m.rxPower > l.high.rxPower, m.rxPower < l.low.rxPower, 6'h00};
    endfunction

    // Index model: half degree plus offset, clamped, with hysteresis
    function automatic int nidx(input int cur, input int t, input bit first);
        int raw;
        raw = (t >>> 1) + 23;
        raw = (raw < 0) ? 0 : ((raw > 75) ? 75 : raw);
        if (first || t >= 2 * cur - 43 || t <= 2 * cur - 48) begin
            return raw;
        end
        return cur;
    endfunction

    // Evaluate, optionally re-evaluate quiet, then read each flag byte twice
    task automatic round(input bit quiet, input bit corner);
        logic [7:0] d;
        logic [7:0] e [4];
        @(posedge ref_clk);
        if (corner) begin
            meas <= {-16'sd50, {4{16'h0005}}};
            critLimits <= {-16'sd60, {4{16'h0005}}, -16'sd40, {4{16'h0005}}};
            minorLimits <= {10{16'h0005}};
        end else begin
            meas <= {rnd(), rnd(), rnd(), rnd(), rnd()};
            critLimits <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            minorLimits <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        end
        evalStrobe <= 1'b1;
        @(posedge ref_clk);
        evalStrobe <= 1'b0;
        e = '{expLo(meas, critLimits), expHi(meas, critLimits),
            expLo(meas, minorLimits), expHi(meas, minorLimits)};
        if (quiet) begin
            @(posedge ref_clk);
            critLimits <= quietLim;
            minorLimits <= quietLim;
            evalStrobe <= 1'b1;
            @(posedge ref_clk);
            evalStrobe <= 1'b0;
            if (followMode) begin
                e = '{default: 8'h00};  // Follow mode keeps only the last result
            end
        end
        for (int i = 0; i < 4; i++) begin
            reg_rd(ofs[i], d);
            chk(16'(d), 16'(e[i]));
            reg_rd(ofs[i], d);
            chk(16'(d), 16'h0000);
        end
    endtask

    // Main sequence
    initial begin
        int cur;
        int t;
        logic [7:0] d;
        logic [3:0] ctl;
        logic [8:0] ea;
        void'($urandom(83));
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values, latch default, unmapped place, released pins
        for (int i = 0; i < 8; i++) begin
            reg_rd(ra[i], d);
            chk(16'(d), 16'(rv[i]));
        end
        // Index walk: corners first, then random temperatures
        cur = 0;
        for (int i = 0; i < 40; i++) begin
            t = (i < 8) ? tl[i] : int'($urandom_range(0, 210)) - 80;
            @(posedge ref_clk);
            tempValid <= 1'b1;
            meas.temp <= 16'(t);
            @(posedge ref_clk);
            tempValid <= 1'b0;
            cur = nidx(cur, t, i == 0);
            @(posedge ref_clk);
            #1;
            ea = (cur > 63) ? 9'h17c + 9'(cur - 64) : 9'h0c0 + 9'(cur);
            chk(16'(tableIndex), 16'(cur));
            chk(16'(tableAddr[3]), 16'(ea));
            reg_rd(8'h7f, d);
            chk(16'(d), 16'(cur));
        end
        // Flags: signed corner, then random rounds, every third re-evaluated quiet
        round(1'b0, 1'b1);
        for (int i = 0; i < 30; i++) begin
            round(i % 3 == 0, 1'b0);
        end
        // Follow mode: nonzero latch field, quiet re-evaluation empties flags
        reg_wr(8'h8c, 8'h30);
        reg_rd(8'h8c, d);
        chk(16'(d), 16'h0030);
        followMode = 1'b1;
        round(1'b1, 1'b0);
        followMode = 1'b0;
        // Transmit off: flags keep working, release clears all
        txOffLevel <= 1'b1;
        repeat (4) @(posedge ref_clk);
        round(1'b0, 1'b0);
        @(posedge ref_clk);
        meas <= {5{16'h00ff}};
        evalStrobe <= 1'b1;
        @(posedge ref_clk);
        evalStrobe <= 1'b0;
        txOffLevel <= 1'b0;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            reg_rd(ofs[i], d);
            chk(16'(d), 16'h0000);
        end
        // Mid-run reset: set flags, then reset clears flags, latch mode, index
        @(posedge ref_clk);
        meas <= {5{16'h00ff}};
        evalStrobe <= 1'b1;
        @(posedge ref_clk);
        evalStrobe <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            reg_rd(ra[i], d);
            chk(16'(d), 16'(rv[i]));
        end
        // Pins: own drive against external pull-downs
        for (int i = 0; i < 16; i++) begin
            ctl = 4'($urandom);
            @(posedge ref_clk);
            extLowN <= 6'($urandom) | 6'($urandom);
            lossDetect <= 1'($urandom);
            faultDetect <= 1'($urandom);
            reg_wr(8'h6e, {4'h0, ctl});
            repeat (4) @(posedge ref_clk);
            reg_rd(8'h6e, d);
            chk(16'(d), 16'({2'b00, {faultDetect, lossDetect, ctl} & extLowN}));
        end
        finish_test();
    end
endmodule

bind mafw_flags mafw_flags_chk i_mafw_flags_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .tempValid(tempValid), .evalStrobe(evalStrobe), .meas(meas), .critLimits(critLimits),
    .minorLimits(minorLimits), .lossDetect(lossDetect), .faultDetect(faultDetect),
    .regReq(regReq), .regRsp(regRsp), .tableIndex(tableIndex), .tableAddr(tableAddr),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN));
